// *** core/cag_addr_gen.v ***
/*
  Address generation for branch targets and data operands of an
  8/16-bit core with a 20-bit space. Assumes the decoder presents one
  request per i_br_req / i_op_req pulse and the memory path answers
  table reads with i_mem_ack one or more cycles after o_mem_req.
*/
// Contract
// - Relative target is next-instruction address plus signed 8 or 16 bit displacement.
// - Relative computation only happens for branch instruction class.
// - Long immediate call or branch loads the 20-bit field directly.
// - Short immediate call or branch zeroes upper four target bits.
// - Table call reads two bytes at 0080H plus twice the 5-bit index.
// - Table-indirect generation is used only by table call.
// - Table-indirect destinations stay within 00000H to 0FFFFH.
// - Register direct target is code bank over selected register pair.
// - Implied operand is decoded only for unsigned multiply with X.
// - Three-bit field picks 8-bit register, two-bit field picks pair.
// - Unprefixed direct operand gets upper nibble F.
// - Prefixed direct and indirect take upper nibble from upper bank register.
// - Short direct byte maps into FFE20H to FFF1FH only.
// - Special register byte maps into FFF00H to FFFFFH only.
// - Unprefixed indirect uses pair as low bits within F0000H to FFFFFH.
`timescale 1ns/100ps
`include "cag_defs.vh"
module cag_addr_gen (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_br_req,
  input wire [2:0] i_br_mode,
  input wire [2:0] i_br_class,
  input wire [19:0] i_next_pc,
  input wire [15:0] i_disp,
  input wire [19:0] i_imm_addr,
  input wire [4:0] i_table_idx,
  input wire [3:0] i_code_bank,
  input wire [1:0] i_rp_sel,
  input wire [15:0] i_rp_ax,
  input wire [15:0] i_rp_bc,
  input wire [15:0] i_rp_de,
  input wire [15:0] i_rp_hl,
  input wire i_mem_ack,
  input wire [7:0] i_mem_rdata,
  input wire i_op_req,
  input wire [2:0] i_op_mode,
  input wire i_op_unsigned_multiply,
  input wire i_op_bank_prefix,
  input wire [2:0] i_reg_sel,
  input wire [15:0] i_op_imm16,
  input wire [7:0] i_op_imm8,
  input wire [3:0] i_upper_bank_register,
  output wire o_mem_req,
  output reg [19:0] o_mem_addr,
  output reg o_pc_load,
  output reg [19:0] o_pc_target,
  output reg o_br_err,
  output wire o_br_busy,
  output reg o_op_valid,
  output reg [19:0] o_op_addr,
  output reg o_op_is_reg,
  output reg [2:0] o_op_reg8,
  output reg [1:0] o_op_reg16,
  output reg o_op_err
);
  // ****************************************
  // Branch target datapath
  // ****************************************
  reg [1:0] ts_q;
  reg [1:0] ts_d;
  localparam TS_IDLE = 2'b00;
  localparam TS_LOW = 2'b01;
  localparam TS_HIGH = 2'b10;
  reg [15:0] rp_val;
  reg [19:0] disp_ext;
  wire [19:0] table_addr;
  wire [15:0] table_word;
  wire tbl_lo_we;
  wire tbl_hi_we;
  wire is_rel;
  wire is_rel_ok;
  wire is_tbl_ok;
  wire is_rp_ok;

  always @* begin
    case (i_rp_sel)
      2'h0: rp_val = i_rp_ax;
      2'h1: rp_val = i_rp_bc;
      2'h2: rp_val = i_rp_de;
      default: rp_val = i_rp_hl;
    endcase
  end

  always @* begin
    if (i_br_mode == `CAG_BR_REL8) begin
      disp_ext = {{12{i_disp[7]}}, i_disp[7:0]};
    end else begin
      disp_ext = {{4{i_disp[15]}}, i_disp};
    end
  end

  assign is_rel = (i_br_mode == `CAG_BR_REL8) || (i_br_mode == `CAG_BR_REL16);
  assign is_rel_ok = i_br_class == `CAG_CLS_BRANCH;
  assign is_tbl_ok = i_br_class == `CAG_CLS_TABLE_CALL;
  assign is_rp_ok = (i_br_class == `CAG_CLS_RP_CALL) ||
                    ((i_br_class == `CAG_CLS_AX_BRANCH) && (i_rp_sel == `CAG_RP_AX));
  // Each entry is two bytes, so the index steps by two within 0080H-00BFH.
  assign table_addr = `CAG_TABLE_BASE + {14'h0000, i_table_idx, 1'b0};

  assign tbl_lo_we = (ts_q == TS_LOW) && i_mem_ack;
  assign tbl_hi_we = (ts_q == TS_HIGH) && i_mem_ack;
  assign o_mem_req = (ts_q == TS_LOW) || (ts_q == TS_HIGH);
  assign o_br_busy = ts_q != TS_IDLE;

  cag_table_latch u_latch (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_lo_we(tbl_lo_we),
    .i_hi_we(tbl_hi_we),
    .i_byte(i_mem_rdata),
    .o_word(table_word)
  );

  always @* begin
    ts_d = ts_q;
    case (ts_q)
      TS_IDLE: begin
        if (i_br_req && (i_br_mode == `CAG_BR_TABLE) && is_tbl_ok) begin
          ts_d = TS_LOW;
        end
      end
      TS_LOW: begin
        if (i_mem_ack) begin
          ts_d = TS_HIGH;
        end
      end
      TS_HIGH: begin
        if (i_mem_ack) begin
          ts_d = TS_IDLE;
        end
      end
      default: ts_d = TS_IDLE;
    endcase
  end

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      ts_q <= TS_IDLE;
      o_mem_addr <= 20'h00000;
      o_pc_load <= 1'b0;
      o_pc_target <= 20'h00000;
      o_br_err <= 1'b0;
    end else begin
      ts_q <= ts_d;
      o_pc_load <= 1'b0;
      o_br_err <= 1'b0;
      if (ts_q == TS_HIGH && i_mem_ack) begin
        // The second byte lands in the latch this edge, so take it from the bus.
        o_pc_load <= 1'b1;
        o_pc_target <= {`CAG_UPPER_ZERO, i_mem_rdata, table_word[7:0]};
      end else if (ts_q == TS_IDLE && i_br_req) begin
        case (i_br_mode)
          `CAG_BR_REL8, `CAG_BR_REL16: begin
            if (is_rel && is_rel_ok) begin
              o_pc_load <= 1'b1;
              o_pc_target <= i_next_pc + disp_ext;
            end else begin
              o_br_err <= 1'b1;
            end
          end
          `CAG_BR_IMM20: begin
            o_pc_load <= 1'b1;
            o_pc_target <= i_imm_addr;
          end
          `CAG_BR_IMM16: begin
            o_pc_load <= 1'b1;
            o_pc_target <= {`CAG_UPPER_ZERO, i_imm_addr[15:0]};
          end
          `CAG_BR_TABLE: begin
            if (is_tbl_ok) begin
              o_mem_addr <= table_addr;
            end else begin
              o_br_err <= 1'b1;
            end
          end
          `CAG_BR_REGPAIR: begin
            if (is_rp_ok) begin
              o_pc_load <= 1'b1;
              o_pc_target <= {i_code_bank, rp_val};
            end else begin
              o_br_err <= 1'b1;
            end
          end
          default: o_br_err <= 1'b1;
        endcase
      end else if (ts_q == TS_LOW && i_mem_ack) begin
        o_mem_addr <= o_mem_addr + 20'h00001;
      end
    end
  end

  // ****************************************
  // Operand address datapath
  // ****************************************
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_op_valid <= 1'b0;
      o_op_addr <= 20'h00000;
      o_op_is_reg <= 1'b0;
      o_op_reg8 <= 3'h0;
      o_op_reg16 <= 2'h0;
      o_op_err <= 1'b0;
    end else begin
      o_op_valid <= 1'b0;
      o_op_err <= 1'b0;
      if (i_op_req) begin
        o_op_valid <= 1'b1;
        o_op_is_reg <= 1'b0;
        case (i_op_mode)
          `CAG_OP_IMPLIED: begin
            if (i_op_unsigned_multiply) begin
              o_op_is_reg <= 1'b1;
              o_op_reg8 <= `CAG_REG_X;
            end else begin
              o_op_valid <= 1'b0;
              o_op_err <= 1'b1;
            end
          end
          `CAG_OP_REG: begin
            o_op_is_reg <= 1'b1;
            o_op_reg8 <= i_reg_sel;
            o_op_reg16 <= i_rp_sel;
          end
          `CAG_OP_DIRECT: begin
            if (i_op_bank_prefix) begin
              o_op_addr <= {i_upper_bank_register, i_op_imm16};
            end else begin
              o_op_addr <= {`CAG_UPPER_F, i_op_imm16};
            end
          end
          `CAG_OP_SHORT: begin
            // Bytes 00H-DFH land from FFE40H upward; E0H-FFH wrap to FFE20H-FFE3FH.
            if (i_op_imm8 < `CAG_SHORT_WRAP) begin
              o_op_addr <= `CAG_SHORT_BASE + {12'h000, i_op_imm8} + 20'h00020;
            end else begin
              o_op_addr <= `CAG_SHORT_BASE + {12'h000, i_op_imm8 - `CAG_SHORT_WRAP};
            end
          end
          `CAG_OP_SPECIAL: begin
            o_op_addr <= `CAG_SPECIAL_BASE + {12'h000, i_op_imm8};
          end
          `CAG_OP_INDIRECT: begin
            if (i_op_bank_prefix) begin
              o_op_addr <= {i_upper_bank_register, rp_val};
            end else begin
              o_op_addr <= {`CAG_UPPER_F, rp_val};
            end
          end
          default: begin
            o_op_valid <= 1'b0;
            o_op_err <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// *** pkg/cag_defs.vh ***
/*
  Constants for the address generation block: mode codes, address
  windows, register field encodings and table-call layout.
  Assumes a 20-bit address space and the plain Verilog include path.
*/
`ifndef CAG_DEFS_VH
`define CAG_DEFS_VH

// ****************************************
// Branch target modes
// ****************************************
`define CAG_BR_NONE 3'h0
`define CAG_BR_REL8 3'h1
`define CAG_BR_REL16 3'h2
`define CAG_BR_IMM20 3'h3
`define CAG_BR_IMM16 3'h4
`define CAG_BR_TABLE 3'h5
`define CAG_BR_REGPAIR 3'h6

// ****************************************
// Branch instruction classes
// ****************************************
`define CAG_CLS_OTHER 3'h0
`define CAG_CLS_BRANCH 3'h1
`define CAG_CLS_TABLE_CALL 3'h2
`define CAG_CLS_RP_CALL 3'h3
`define CAG_CLS_AX_BRANCH 3'h4

// ****************************************
// Operand address modes
// ****************************************
`define CAG_OP_NONE 3'h0
`define CAG_OP_IMPLIED 3'h1
`define CAG_OP_REG 3'h2
`define CAG_OP_DIRECT 3'h3
`define CAG_OP_SHORT 3'h4
`define CAG_OP_SPECIAL 3'h5
`define CAG_OP_INDIRECT 3'h6

// ****************************************
// Address windows
// ****************************************
`define CAG_UPPER_F 4'hf
`define CAG_UPPER_ZERO 4'h0
`define CAG_TABLE_BASE 20'h00080
`define CAG_SHORT_BASE 20'hffe20
`define CAG_SHORT_WRAP 8'he0
`define CAG_SPECIAL_BASE 20'hfff00

// ****************************************
// Register encodings
// ****************************************
`define CAG_REG_X 3'h0
`define CAG_RP_AX 2'h0

`endif

// *** core/cag_table_latch.v ***
/*
  Holds the two bytes of a table-call entry and joins them into a
  16-bit target. Assumes byte strobes come from the same clock domain.
*/
`timescale 1ns/100ps
module cag_table_latch (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_lo_we,
  input wire i_hi_we,
  input wire [7:0] i_byte,
  output wire [15:0] o_word
);
  reg [7:0] lo_q;
  reg [7:0] hi_q;

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      lo_q <= 8'h00;
      hi_q <= 8'h00;
    end else begin
      if (i_lo_we) begin
        lo_q <= i_byte;
      end
      if (i_hi_we) begin
        hi_q <= i_byte;
      end
    end
  end

  assign o_word = {hi_q, lo_q};
endmodule

// *** test/cag_addr_gen_sva.sv ***
/*
  Checker for the address generation block: timing and value relations
  between requests and answers. Assumes the bind in the bench top file.
*/
`timescale 1ns/100ps
`include "cag_defs.vh"
module cag_addr_gen_chk (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_br_req,
  input wire [2:0] i_br_mode,
  input wire [2:0] i_br_class,
  input wire [19:0] i_next_pc,
  input wire [15:0] i_disp,
  input wire [4:0] i_table_idx,
  input wire i_op_req,
  input wire [2:0] i_op_mode,
  input wire i_op_unsigned_multiply,
  input wire i_op_bank_prefix,
  input wire [15:0] i_op_imm16,
  input wire [7:0] i_op_imm8,
  input wire o_mem_req,
  input wire [19:0] o_mem_addr,
  input wire o_pc_load,
  input wire [19:0] o_pc_target,
  input wire o_br_err,
  input wire o_br_busy,
  input wire o_op_valid,
  input wire [19:0] o_op_addr,
  input wire o_op_err
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // ****************************************
  // Branch targets
  // ****************************************
  sequence s_take;
    i_br_req && !o_br_busy;
  endsequence
  sequence s_tbl;
    s_take ##0 i_br_mode == `CAG_BR_TABLE && i_br_class == `CAG_CLS_TABLE_CALL;
  endsequence
  a_rel16_sum: assert property (s_take ##0 i_br_mode == `CAG_BR_REL16 &&
    i_br_class == `CAG_CLS_BRANCH |=> o_pc_load &&
    o_pc_target == $past(i_next_pc) + {{4{$past(i_disp[15])}}, $past(i_disp)})
    else $error("relative target wrong");
  a_rel_class_only: assert property (s_take ##0 i_br_class != `CAG_CLS_BRANCH &&
    (i_br_mode == `CAG_BR_REL8 || i_br_mode == `CAG_BR_REL16) |=> o_br_err && !o_pc_load)
    else $error("relative accepted outside branch");
  a_tbl_first: assert property (s_tbl |=> o_mem_req && o_br_busy &&
    o_mem_addr == `CAG_TABLE_BASE + {$past(i_table_idx), 1'b0})
    else $error("table address wrong");
  a_tbl_upper: assert property (o_pc_load && $past(o_br_busy) |->
    o_pc_target[19:16] == 4'h0) else $error("table target above 64k");
  // ****************************************
  // Operand addresses
  // ****************************************
  a_implied_mul: assert property (i_op_req && i_op_mode == `CAG_OP_IMPLIED &&
    !i_op_unsigned_multiply |=> o_op_err && !o_op_valid) else $error("implied accepted");
  a_direct_f: assert property (i_op_req && i_op_mode == `CAG_OP_DIRECT &&
    !i_op_bank_prefix |=> o_op_valid && o_op_addr == {4'hf, $past(i_op_imm16)})
    else $error("direct upper bits wrong");
  a_short_window: assert property (i_op_req && i_op_mode == `CAG_OP_SHORT |=>
    o_op_addr >= 20'hffe20 && o_op_addr <= 20'hfff1f) else $error("short outside window");
  a_special_map: assert property (i_op_req && i_op_mode == `CAG_OP_SPECIAL |=>
    o_op_valid && o_op_addr == `CAG_SPECIAL_BASE + $past(i_op_imm8))
    else $error("special address wrong");
endmodule

// *** test/cag_addr_gen_bench.sv ***
/*
  Self-checking bench for the address generation block. Assumes the
  block answers one cycle after a request.
*/
`timescale 1ns/100ps
`include "cag_defs.vh"
module cag_addr_gen_bench;
  reg i_core_clk = 0, i_rst = 1, i_br_req = 0, i_mem_ack = 0, i_op_req = 0;
  reg i_op_unsigned_multiply = 0, i_op_bank_prefix = 0;
  reg [2:0] i_br_mode = 0, i_br_class = 0, i_op_mode = 0, i_reg_sel = 0;
  reg [19:0] i_next_pc = 0, i_imm_addr = 0;
  reg [15:0] i_disp = 0, i_op_imm16 = 16'h4321, i_rp_ax = 16'ha0a1, i_rp_bc = 16'hb0b1;
  reg [15:0] i_rp_de = 16'hc0c1, i_rp_hl = 16'hd0d1;
  reg [4:0] i_table_idx = 0;
  reg [3:0] i_code_bank = 4'h7, i_upper_bank_register = 4'h5;
  reg [1:0] i_rp_sel = 0;
  reg [7:0] i_mem_rdata = 0, i_op_imm8 = 0;
  wire o_mem_req, o_pc_load, o_br_err, o_br_busy, o_op_valid, o_op_is_reg, o_op_err;
  wire [19:0] o_mem_addr, o_pc_target, o_op_addr;
  wire [2:0] o_op_reg8;
  wire [1:0] o_op_reg16;
  int err_count = 0, n_checks = 0;
  // The bench stands for a part with more than 128 bytes of RAM.
  localparam bit small_ram = 1'b0;
  cag_addr_gen dut_u (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_br_req(i_br_req), .i_br_mode(i_br_mode),
    .i_br_class(i_br_class), .i_next_pc(i_next_pc), .i_disp(i_disp),
    .i_imm_addr(i_imm_addr), .i_table_idx(i_table_idx), .i_code_bank(i_code_bank),
    .i_rp_sel(i_rp_sel), .i_rp_ax(i_rp_ax), .i_rp_bc(i_rp_bc), .i_rp_de(i_rp_de),
    .i_rp_hl(i_rp_hl), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
    .i_op_req(i_op_req), .i_op_mode(i_op_mode),
    .i_op_unsigned_multiply(i_op_unsigned_multiply), .i_op_bank_prefix(i_op_bank_prefix),
    .i_reg_sel(i_reg_sel), .i_op_imm16(i_op_imm16), .i_op_imm8(i_op_imm8),
    .i_upper_bank_register(i_upper_bank_register), .o_mem_req(o_mem_req),
    .o_mem_addr(o_mem_addr), .o_pc_load(o_pc_load), .o_pc_target(o_pc_target),
    .o_br_err(o_br_err), .o_br_busy(o_br_busy), .o_op_valid(o_op_valid),
    .o_op_addr(o_op_addr), .o_op_is_reg(o_op_is_reg), .o_op_reg8(o_op_reg8),
    .o_op_reg16(o_op_reg16), .o_op_err(o_op_err)
  );
  initial forever #4 i_core_clk = ~i_core_clk;
  // ****************************************
  // Shared helpers
  // ****************************************
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task cmp(input logic [23:0] g, e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %0t got %h want %h", $time, g, e);
    end
  endtask
  task br(input [2:0] m, c, input [19:0] e, input bad);
    @(negedge i_core_clk);
    i_br_mode = m;
    i_br_class = c;
    i_br_req = 1;
    @(negedge i_core_clk);
    i_br_req = 0;
    cmp({o_pc_load, o_br_err}, {!bad, bad});
    if (!bad) cmp(o_pc_target, e);
  endtask
  task op(input [2:0] m, input mu, pre, bad);
    @(negedge i_core_clk);
    i_op_mode = m;
    i_op_unsigned_multiply = mu;
    i_op_bank_prefix = pre;
    i_op_req = 1;
    @(negedge i_core_clk);
    i_op_req = 0;
    cmp({o_op_valid, o_op_err}, {!bad, bad});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_rel;
    i_next_pc = 20'h01000;
    i_disp = 16'h0080;
    br(`CAG_BR_REL8, `CAG_CLS_BRANCH, 20'h00f80, 0);
    i_next_pc = 20'hffff0;
    i_disp = 16'h7fff;
    br(`CAG_BR_REL16, `CAG_CLS_BRANCH, 20'h07fef, 0);
    br(`CAG_BR_REL8, `CAG_CLS_OTHER, 0, 1);
  endtask
  task t_imm_rp;
    i_imm_addr = 20'hbcdef;
    br(`CAG_BR_IMM20, `CAG_CLS_BRANCH, 20'hbcdef, 0);
    br(`CAG_BR_IMM16, `CAG_CLS_BRANCH, 20'h0cdef, 0);
    i_rp_sel = 3;
    br(`CAG_BR_REGPAIR, `CAG_CLS_RP_CALL, 20'h7d0d1, 0);
    i_rp_sel = 1;
    br(`CAG_BR_REGPAIR, `CAG_CLS_AX_BRANCH, 0, 1);
    br(`CAG_BR_TABLE, `CAG_CLS_BRANCH, 0, 1);
  endtask
  task t_tbl(input [4:0] x, input [7:0] lo, hi);
    int k;
    i_table_idx = x;
    @(negedge i_core_clk);
    i_br_mode = `CAG_BR_TABLE;
    i_br_class = `CAG_CLS_TABLE_CALL;
    i_br_req = 1;
    @(negedge i_core_clk);
    i_br_req = 0;
    cmp({o_mem_req, o_br_busy, o_mem_addr}, {2'b11, `CAG_TABLE_BASE + {x, 1'b0}});
    i_mem_ack = 1;
    i_mem_rdata = lo;
    @(negedge i_core_clk);
    cmp(o_mem_addr, `CAG_TABLE_BASE + {x, 1'b1});
    i_mem_rdata = hi;
    @(negedge i_core_clk);
    i_mem_ack = 0;
    i_mem_rdata = ~hi;
    k = 0;
    while (o_pc_load !== 1'b1 && k < 4) begin
      @(negedge i_core_clk);
      k++;
    end
    cmp({o_pc_load, o_br_busy, o_pc_target}, {2'b10, 4'h0, hi, lo});
  endtask
  task t_ops;
    op(`CAG_OP_IMPLIED, 1, 0, 0);
    cmp(o_op_reg8, `CAG_REG_X);
    op(`CAG_OP_IMPLIED, 0, 0, 1);
    i_reg_sel = 5;
    i_rp_sel = 2;
    op(`CAG_OP_REG, 0, 0, 0);
    cmp({o_op_is_reg, o_op_reg8, o_op_reg16}, {1'b1, 3'h5, 2'h2});
    op(`CAG_OP_DIRECT, 0, 0, 0);
    cmp(o_op_addr, 20'hf4321);
    op(`CAG_OP_DIRECT, 0, 1, 0);
    cmp(o_op_addr, 20'h54321);
    op(`CAG_OP_INDIRECT, 0, 1, 0);
    cmp(o_op_addr, 20'h5c0c1);
    op(`CAG_OP_INDIRECT, 0, 0, 0);
    cmp(o_op_addr, 20'hfc0c1);
    i_op_imm8 = 8'hff;
    op(`CAG_OP_SPECIAL, 0, 0, 0);
    cmp(o_op_addr, 20'hfffff);
    // A wide special register is only ever named at its even byte.
    i_op_imm8 = 8'hf8;
    op(`CAG_OP_SPECIAL, 0, 0, 0);
    cmp(o_op_addr, 20'hffff8);
    // A pair operand in the short window is only ever named at its even byte.
    i_op_imm8 = 8'h30;
    op(`CAG_OP_SHORT, 0, 0, 0);
    cmp(o_op_addr, 20'hffe70);
    for (int b = 0; b < 256; b++) begin
      // Bytes landing in FFEE0H-FFEF7H are never issued, nor the low window on small parts.
      if ((b >= 8'ha0 && b <= 8'hb7) || (small_ram && (b < 8'h20 || b >= 8'he0))) begin
        continue;
      end
      i_op_imm8 = b[7:0];
      op(`CAG_OP_SHORT, 0, 0, 0);
      cmp(o_op_addr, b < 224 ? 20'hffe40 + b : 20'hffe20 + b - 224);
    end
  endtask
  initial begin
    repeat (8) @(negedge i_core_clk);
    i_rst = 0;
    t_rel;
    t_imm_rp;
    t_tbl(5'h00, 8'h34, 8'h12);
    t_tbl(5'h1f, 8'hcd, 8'hab);
    t_ops;
    print_verdict;
  end
  // A hang in any wait loop ends the run here instead of running forever.
  initial begin
    #40000;
    err_count++;
    print_verdict;
  end
endmodule
bind cag_addr_gen cag_addr_gen_chk chk_u (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_br_req(i_br_req), .i_br_mode(i_br_mode),
  .i_br_class(i_br_class), .i_next_pc(i_next_pc), .i_disp(i_disp),
  .i_table_idx(i_table_idx), .i_op_req(i_op_req), .i_op_mode(i_op_mode),
  .i_op_unsigned_multiply(i_op_unsigned_multiply), .i_op_bank_prefix(i_op_bank_prefix),
  .i_op_imm16(i_op_imm16), .i_op_imm8(i_op_imm8), .o_mem_req(o_mem_req),
  .o_mem_addr(o_mem_addr), .o_pc_load(o_pc_load), .o_pc_target(o_pc_target),
  .o_br_err(o_br_err), .o_br_busy(o_br_busy), .o_op_valid(o_op_valid),
  .o_op_addr(o_op_addr), .o_op_err(o_op_err)
);
